// file: hoc_pkg.sv
`default_nettype none
package hoc_pkg;

    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [7:0] ADDR_CTRL    = 8'hb2;
    localparam logic [7:0] ADDR_TRIM    = 8'hb3;

    // Control register field positions
    localparam int         CTRL_EN_BIT   = 7;
    localparam int         CTRL_RDY_BIT  = 6;
    localparam int         CTRL_SUSP_BIT = 5;
    localparam int         CTRL_SYNC_BIT = 4;
    localparam int         CTRL_DIV_LSB  = 0;
    localparam int         TRIM_W        = 7;

    // ******************************************************************
    // Values after reset
    // ******************************************************************
    localparam logic       EN_RST       = 1'b1;
    localparam logic       RDY_RST      = 1'b1;
    localparam logic       SUSP_RST     = 1'b0;
    localparam logic [1:0] DIV_RST      = 2'h0;

    // Divider field codes
    localparam logic [1:0] DIV_16       = 2'h0;
    localparam logic [1:0] DIV_8        = 2'h1;
    localparam logic [1:0] DIV_4        = 2'h2;
    localparam logic [1:0] DIV_2        = 2'h3;

    // Counter limits, one tick per ratio cycles
    localparam logic [3:0] LIM_16       = 4'hf;
    localparam logic [3:0] LIM_8        = 4'h7;
    localparam logic [3:0] LIM_4        = 4'h3;
    localparam logic [3:0] LIM_2        = 4'h1;

    // Timer clocks the sync flag stays up after a non-timer wake
    localparam logic [1:0] SYNC_TICKS   = 2'h3;

    // Wake source indices
    localparam int         WAKE_N       = 4;
    localparam int         WK_TIMER     = 3;

    // ******************************************************************
    // Suspend state machine
    // ******************************************************************
    typedef enum logic [2:0]
    {
        ST_RUN  = 3'b001,
        ST_SUSP = 3'b010,
        ST_WAKE = 3'b100
    } hoc_state_t;

endpackage
`default_nettype wire

// file: hoc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hoc_link_if;
    logic       run;      // Oscillator running
    logic       direct;   // Undivided clock
    logic [1:0] sel;      // Divider code
    logic       restart;  // Realign divider phase
    logic       tick;     // Clock enable pulse
    logic       armed;    // Suspended, waiting for wake
    logic       wake;     // Wake pulse
    logic       sync_busy; // Timer not yet resynchronised

    modport ctrl (output run, direct, sel, restart, armed, input tick, wake, sync_busy);
    modport div  (input run, direct, sel, restart, output tick);
    modport wk   (input armed, output wake, sync_busy);
endinterface
`default_nettype wire

// file: hoc_post_div.sv
`timescale 1ns/1ps
`default_nettype none
module hoc_post_div
(
    input  wire logic  sys_clk,  // Clock
    input  wire logic  resetn,   // Sync reset, low
    hoc_link_if.div    dv        // Divider controls
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       tick_q;
    logic       tick_d;
    logic [3:0] lim;

    // ******************************************************************
    // Whole-period enables keep restarted clocks free of runts
    // ******************************************************************
    always_comb
    begin
        case (dv.sel)
            hoc_pkg::DIV_16: lim = hoc_pkg::LIM_16;
            hoc_pkg::DIV_8:  lim = hoc_pkg::LIM_8;
            hoc_pkg::DIV_4:  lim = hoc_pkg::LIM_4;
            hoc_pkg::DIV_2:  lim = hoc_pkg::LIM_2;
            default:         lim = hoc_pkg::LIM_16;
        endcase
        cnt_d  = 4'h0;
        tick_d = 1'b0;
        if (!dv.run || dv.restart)
        begin
            cnt_d  = 4'h0;
        end
        else if (dv.direct)
        begin
            tick_d = 1'b1;
        end
        else if (cnt_q == lim)
        begin
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;

endmodule
`default_nettype wire

// file: hoc_wake_det.sv
`timescale 1ns/1ps
`default_nettype none
module hoc_wake_det
(
    input  wire logic                       sys_clk,    // Clock
    input  wire logic                       resetn,     // Sync reset, low
    input  wire logic [hoc_pkg::WAKE_N-1:0] wake_src,   // Wake event levels
    input  wire logic                       timer_tick, // Wake timer clock pulse
    hoc_link_if.wk                          wk          // Wake handshake
);

    logic [hoc_pkg::WAKE_N-1:0] hit;
    logic                       wake_q;
    logic                       wake_d;
    logic [1:0]                 sync_q;
    logic [1:0]                 sync_d;

    // Sources sampled on the free-running reference, not the gated clock
    genvar gi;
    generate
        for (gi = 0; gi < hoc_pkg::WAKE_N; gi = gi + 1)
        begin : g_src
            assign hit[gi] = wk.armed & wake_src[gi];
        end
    endgenerate

    always_comb
    begin
        wake_d = |hit;
        sync_d = sync_q;
        // Timer wakes need no resync, so only other sources raise the flag
        if ((|hit) && !hit[hoc_pkg::WK_TIMER])
        begin
            sync_d = hoc_pkg::SYNC_TICKS;
        end
        else if (timer_tick && (sync_q != 2'h0))
        begin
            sync_d = sync_q - 2'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            wake_q <= 1'b0;
            sync_q <= 2'h0;
        end
        else
        begin
            wake_q <= wake_d;
            sync_q <= sync_d;
        end
    end

    assign wk.wake      = wake_q;
    assign wk.sync_busy = (sync_q != 2'h0);

endmodule
`default_nettype wire

// file: hoc_osc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module hoc_osc_ctrl
#(
    parameter int TRIM_W = hoc_pkg::TRIM_W  // Trim field width
)
(
    input  wire logic              sys_clk,        // 250 MHz reference clock
    input  wire logic              resetn,         // Sync reset, low
    input  wire logic [7:0]        sfr_addr,       // Register address
    input  wire logic              sfr_wr,         // Write strobe
    input  wire logic              sfr_rd,         // Read strobe
    input  wire logic [7:0]        sfr_wdata,      // Write data
    output logic      [7:0]        sfr_rdata,      // Read data, next cycle
    input  wire logic [TRIM_W-1:0] factory_trim,   // Per-part calibration value
    input  wire logic              hf_selected,    // Oscillator is system clock source
    input  wire logic              hf_direct,      // Undivided source selected
    input  wire logic              osc_stable,     // Analog settled indication
    input  wire logic              p0_match,       // Port 0 match event
    input  wire logic              p1_match,       // Port 1 match event
    input  wire logic              cmp0_en,        // Comparator 0 enabled
    input  wire logic              cmp0_out,       // Comparator 0 output
    input  wire logic              t3_ovf,         // Timer 3 overflow event
    input  wire logic              wake_timer_tick, // Wake timer clock pulse
    output logic                   osc_run,        // Oscillator enable to analog
    output logic      [TRIM_W-1:0] hf_osc_trim,    // Trim to analog
    output logic                   core_clk_en,    // Processor core clock enable
    output logic                   periph_clk_en   // Peripheral clock enable
);

    // ******************************************************************
    // Declarations
    // ******************************************************************
    // Controls to the divider and wake detector travel together
    hoc_link_if lk ();

    hoc_pkg::hoc_state_t st_q;
    hoc_pkg::hoc_state_t st_d;

    logic              en_q;
    logic              en_d;
    logic              rdy_q;
    logic              rdy_d;
    logic              susp_q;
    logic              susp_d;
    logic [1:0]        div_q;
    logic [1:0]        div_d;
    logic [TRIM_W-1:0] trim_q;
    logic [TRIM_W-1:0] trim_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic              osc_q;
    logic              osc_d;
    logic              core_q;
    logic              core_d;
    logic              peri_q;
    logic              peri_d;

    logic              wr_ctrl;
    logic              wr_trim;
    logic [7:0]        ctrl_rd;
    logic [hoc_pkg::WAKE_N-1:0] wake_src;

    // ******************************************************************
    // Address decode
    // ******************************************************************
    assign wr_ctrl = sfr_wr && (sfr_addr == hoc_pkg::ADDR_CTRL);
    assign wr_trim = sfr_wr && (sfr_addr == hoc_pkg::ADDR_TRIM);

    // ******************************************************************
    // Wake sources
    // ******************************************************************
    // Comparator only counts while enabled and low
    assign wake_src = {t3_ovf, cmp0_en & ~cmp0_out, p1_match, p0_match};

    // ******************************************************************
    // Sub-blocks
    // ******************************************************************
    hoc_post_div hoc_post_div_inst
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .dv      (lk.div)
    );

    // Wake detection runs on the free reference so it works while gated
    hoc_wake_det hoc_wake_det_inst
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .wake_src   (wake_src),
        .timer_tick (wake_timer_tick),
        .wk         (lk.wk)
    );

    // Restart lasts one cycle so the divider begins a whole period
    assign lk.run     = osc_q;
    assign lk.direct  = hf_direct;
    assign lk.sel     = div_q;
    assign lk.restart = (st_q == hoc_pkg::ST_WAKE);
    assign lk.armed   = (st_q == hoc_pkg::ST_SUSP);

    // ******************************************************************
    // Suspend state machine
    // ******************************************************************
    always_comb
    begin
        st_d   = st_q;
        susp_d = susp_q;
        case (st_q)
            hoc_pkg::ST_RUN:
            begin
                if (wr_ctrl && sfr_wdata[hoc_pkg::CTRL_SUSP_BIT])
                begin
                    susp_d = 1'b1;
                    st_d   = hoc_pkg::ST_SUSP;
                end
                else if (wr_ctrl)
                begin
                    susp_d = 1'b0;
                end
            end
            hoc_pkg::ST_SUSP:
            begin
                if (lk.wake)
                begin
                    st_d = hoc_pkg::ST_WAKE;
                end
            end
            hoc_pkg::ST_WAKE:
            begin
                // Divider realigned this cycle, clocks resume next
                susp_d = 1'b0;
                st_d   = hoc_pkg::ST_RUN;
            end
            default:
            begin
                susp_d = 1'b0;
                st_d   = hoc_pkg::ST_RUN;
            end
        endcase
    end

    // State and suspend bit move together so a read never sees them split
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_q   <= hoc_pkg::ST_RUN;
            susp_q <= hoc_pkg::SUSP_RST;
        end
        else
        begin
            st_q   <= st_d;
            susp_q <= susp_d;
        end
    end

    // ******************************************************************
    // Register file
    // ******************************************************************
    always_comb
    begin
        en_d   = en_q;
        div_d  = div_q;
        trim_d = trim_q;
        // A suspending write loads enable and divider as well
        if (wr_ctrl)
        begin
            en_d  = sfr_wdata[hoc_pkg::CTRL_EN_BIT];
            div_d = sfr_wdata[hoc_pkg::CTRL_DIV_LSB +: 2];
        end
        if (wr_trim)
        begin
            trim_d = sfr_wdata[TRIM_W-1:0];
        end
    end

    // Trim reloads the per-part value on every reset, never a constant
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            en_q   <= hoc_pkg::EN_RST;
            div_q  <= hoc_pkg::DIV_RST;
            trim_q <= factory_trim;
        end
        else
        begin
            en_q   <= en_d;
            div_q  <= div_d;
            trim_q <= trim_d;
        end
    end

    // ******************************************************************
    // Read path
    // ******************************************************************
    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[hoc_pkg::CTRL_EN_BIT]        = en_q;
        ctrl_rd[hoc_pkg::CTRL_RDY_BIT]       = rdy_q;
        ctrl_rd[hoc_pkg::CTRL_SUSP_BIT]      = susp_q;
        ctrl_rd[hoc_pkg::CTRL_SYNC_BIT]      = lk.sync_busy;
        ctrl_rd[hoc_pkg::CTRL_DIV_LSB +: 2]  = div_q;
        rdata_d = rdata_q;
        if (sfr_rd)
        begin
            if (sfr_addr == hoc_pkg::ADDR_CTRL)
            begin
                rdata_d = ctrl_rd;
            end
            else if (sfr_addr == hoc_pkg::ADDR_TRIM)
            begin
                // Top bit is unused and always reads zero
                rdata_d = {1'b0, trim_q};
            end
            else
            begin
                rdata_d = 8'h00;
            end
        end
    end

    // Read data holds between reads
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ******************************************************************
    // Oscillator and clock gating
    // ******************************************************************
    always_comb
    begin
        // Disabling while sourcing sysclk stops everything until reset
        osc_d  = en_q && (st_q != hoc_pkg::ST_SUSP);
        // Ready drops one cycle after the oscillator stops
        rdy_d  = osc_q && osc_stable;
        // Clocks held whenever the selected oscillator is stopped; the core stalls
        // mid-instruction so it continues after the suspending write.
        // The tick lags the stop by one cycle, so it is gated with osc_q.
        core_d = hf_selected ? (lk.tick && osc_q) : 1'b1;
        peri_d = hf_selected ? (lk.tick && osc_q) : 1'b1;
        if (st_q == hoc_pkg::ST_SUSP)
        begin
            core_d = ~hf_selected;
            peri_d = ~hf_selected;
        end
    end

    // Every output leaves straight from a flop, never through a gate
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdy_q   <= hoc_pkg::RDY_RST;
            osc_q   <= hoc_pkg::EN_RST;
            core_q  <= 1'b0;
            peri_q  <= 1'b0;
        end
        else
        begin
            rdy_q   <= rdy_d;
            osc_q   <= osc_d;
            core_q  <= core_d;
            peri_q  <= peri_d;
        end
    end

    assign sfr_rdata     = rdata_q;
    assign osc_run       = osc_q;
    assign hf_osc_trim   = trim_q;
    assign core_clk_en   = core_q;
    assign periph_clk_en = peri_q;

endmodule
`default_nettype wire

// file: hoc_osc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hoc_osc_ctrl_chk
#(
    parameter int TRIM_W = hoc_pkg::TRIM_W  // Trim width
)
(
    input wire logic              sys_clk,         // Clock
    input wire logic              resetn,          // Reset, low
    input wire logic [7:0]        sfr_addr,        // Address
    input wire logic              sfr_wr,          // Write strobe
    input wire logic              sfr_rd,          // Read strobe
    input wire logic [7:0]        sfr_wdata,       // Write data
    input wire logic [7:0]        sfr_rdata,       // Read data
    input wire logic [TRIM_W-1:0] factory_trim,    // Factory trim
    input wire logic              hf_selected,     // Source selected
    input wire logic              hf_direct,       // Undivided
    input wire logic              osc_stable,      // Settled
    input wire logic              p0_match,        // Wake
    input wire logic              p1_match,        // Wake
    input wire logic              cmp0_en,         // Comparator on
    input wire logic              cmp0_out,        // Comparator out
    input wire logic              t3_ovf,          // Wake
    input wire logic              wake_timer_tick, // Timer tick
    input wire logic              osc_run,         // Oscillator on
    input wire logic [TRIM_W-1:0] hf_osc_trim,     // Trim out
    input wire logic              core_clk_en,     // Core enable
    input wire logic              periph_clk_en    // Peripheral enable
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    wire logic              wk_any = p0_match | p1_match | t3_ovf | (cmp0_en & ~cmp0_out);
    wire logic [TRIM_W-1:0] w_trim = sfr_wdata[TRIM_W-1:0];

    a_reset_values: assert property (
        $rose(resetn) |-> osc_run && !core_clk_en && hf_osc_trim == factory_trim && sfr_rdata == 8'h00)
        else $error("reset values wrong");
    a_trim_write: assert property (
        sfr_wr && sfr_addr == hoc_pkg::ADDR_TRIM |=> hf_osc_trim == $past(w_trim))
        else $error("trim write lost");
    a_trim_read: assert property (
        sfr_rd && !sfr_wr && sfr_addr == hoc_pkg::ADDR_TRIM |=> sfr_rdata == {1'b0, $past(hf_osc_trim)})
        else $error("trim read wrong");
    a_unmapped_read: assert property (
        sfr_rd && sfr_addr != hoc_pkg::ADDR_TRIM && sfr_addr != hoc_pkg::ADDR_CTRL |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    a_enables_equal: assert property (core_clk_en == periph_clk_en)
        else $error("enables differ");
    a_stopped_quiet: assert property (
        (hf_selected && !osc_run) [*2] |-> !core_clk_en)
        else $error("pulse while stopped");
    a_other_source: assert property (!hf_selected ##1 !hf_selected |-> core_clk_en)
        else $error("enable low on other source");
    a_pulse_width: assert property (
        (hf_selected && !hf_direct) [*3] ##0 core_clk_en |=> !core_clk_en)
        else $error("divided pulse too wide");
    a_suspend_stops: assert property (
        sfr_wr && sfr_addr == hoc_pkg::ADDR_CTRL && sfr_wdata[5] && osc_run && !wk_any |-> ##[1:3] !osc_run)
        else $error("suspend did not stop");
    a_wake_resumes: assert property (
        hf_selected && !osc_run && wk_any |-> ##[1:6] osc_run)
        else $error("wake did not restart");

    c_suspend: cover property (sfr_wr && sfr_addr == hoc_pkg::ADDR_CTRL && sfr_wdata[5]);
    c_restart: cover property ($rose(osc_run));
    c_direct:  cover property (hf_selected && hf_direct && core_clk_en);
endmodule

bind hoc_osc_ctrl hoc_osc_ctrl_chk #(.TRIM_W(TRIM_W)) chk_inst (.sys_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .factory_trim, .hf_selected, .hf_direct, .osc_stable, .p0_match, .p1_match, .cmp0_en,
    .cmp0_out, .t3_ovf, .wake_timer_tick, .osc_run, .hf_osc_trim, .core_clk_en, .periph_clk_en);
`default_nettype wire

// file: hoc_osc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hoc_osc_ctrl_tb;
    localparam logic [7:0] CT = hoc_pkg::ADDR_CTRL;
    localparam logic [7:0] TR = hoc_pkg::ADDR_TRIM;
    localparam logic [6:0] FT = 7'h5a;  // Arbitrary calibration value

    logic       sys_clk, resetn, sfr_wr, sfr_rd, hf_selected, hf_direct, osc_stable;
    logic       p0_match, p1_match, cmp0_en, cmp0_out, t3_ovf, wake_timer_tick;
    logic       osc_run, core_clk_en, periph_clk_en;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [6:0] factory_trim, hf_osc_trim;
    int         mismatches = 0;
    int         tests_run = 0;

    hoc_osc_ctrl hoc_osc_ctrl_inst (.sys_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .factory_trim, .hf_selected, .hf_direct, .osc_stable, .p0_match, .p1_match, .cmp0_en, .cmp0_out,
        .t3_ovf, .wake_timer_tick, .osc_run, .hf_osc_trim, .core_clk_en, .periph_clk_en);

    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    // ****************
    // Access tasks
    // ****************
    task summarize;
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        tests_run++;
        if (got_v !== exp_v)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task timeout;
        mismatches++;
        $display("ERROR %0t wait ran out", $time);
        summarize;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr    <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp_v);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(sfr_rdata, exp_v);
    endtask

    // Spacing between two enable pulses, in cycles
    task period(input int exp_n);
        int n;
        n = 0;
        while (core_clk_en !== 1'b1)
        begin
            @(negedge sys_clk);
            if (++n > 40) timeout;
        end
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (core_clk_en !== 1'b1 && n < 40);
        chk(8'(n), 8'(exp_n));
    endtask

    // Suspend at divide-by-2, then wake from one source
    task wake(input int src);
        int n;
        wr(CT, 8'ha3);
        repeat (4) @(negedge sys_clk);
        chk({5'h0, osc_run, core_clk_en, periph_clk_en}, 8'h00);
        rd(CT, 8'ha3);
        @(posedge sys_clk);
        if (src == 2)
        begin
            cmp0_out <= 1'b0;
            repeat (6) @(negedge sys_clk);
            chk({7'h0, osc_run}, 8'h00);
            @(posedge sys_clk);
        end
        case (src)
            0: p0_match <= 1'b1;
            1: p1_match <= 1'b1;
            2: cmp0_en  <= 1'b1;
            default: t3_ovf <= 1'b1;
        endcase
        @(posedge sys_clk);
        {p0_match, p1_match, cmp0_en, t3_ovf} <= 4'h0;
        cmp0_out <= 1'b1;
        n = 0;
        while (osc_run !== 1'b1)
        begin
            @(negedge sys_clk);
            if (++n > 10) timeout;
        end
        period(2);
        rd(CT, (src == 3) ? 8'hc3 : 8'hd3);
        repeat (3)
        begin
            @(posedge sys_clk);
            wake_timer_tick <= 1'b1;
            @(posedge sys_clk);
            wake_timer_tick <= 1'b0;
        end
        rd(CT, 8'hc3);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
        {hf_direct, p0_match, p1_match, cmp0_en, t3_ovf, wake_timer_tick} = '0;
        {hf_selected, osc_stable, cmp0_out} = 3'b111;
        factory_trim = FT;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(CT, 8'hc0);
        rd(TR, {1'b0, FT});
        chk({1'b0, hf_osc_trim}, {1'b0, FT});
        period(16);
        wr(TR, 8'hff);
        rd(TR, 8'h7f);
        wr(TR, 8'h00);
        rd(TR, 8'h00);
        chk({1'b0, hf_osc_trim}, 8'h00);
        wr(8'hb4, 8'h55);
        rd(8'hb4, 8'h00);
        rd(TR, 8'h00);
        @(posedge sys_clk);
        osc_stable <= 1'b0;
        wr(CT, 8'hdc);
        rd(CT, 8'h80);
        @(posedge sys_clk);
        osc_stable <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(CT, 8'h80 | 8'(c));
            rd(CT, 8'hc0 | 8'(c));
            period(16 >> c);
        end
        @(posedge sys_clk);
        hf_direct <= 1'b1;
        repeat (3) @(posedge sys_clk);
        repeat (4) @(negedge sys_clk) chk({6'h0, periph_clk_en, core_clk_en}, 8'h03);
        @(posedge sys_clk);
        hf_direct   <= 1'b0;
        hf_selected <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({6'h0, periph_clk_en, core_clk_en}, 8'h03);
        @(posedge sys_clk);
        hf_selected <= 1'b1;
        for (int s = 0; s < 4; s++) wake(s);
        // Disabling the running source stalls the core until the next reset
        wr(CT, 8'h03);
        repeat (3) @(posedge sys_clk);
        rd(CT, 8'h03);
        chk({7'h0, osc_run}, 8'h00);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(CT, 8'hc0);
        rd(TR, {1'b0, FT});
        chk({1'b0, hf_osc_trim}, {1'b0, FT});
        summarize;
    end
endmodule
`default_nettype wire
